// ===== pkg/lcb_regs.vh
// constants for the lcd bias control register pair
`ifndef LCB_REGS_VH
`define LCB_REGS_VH

// register indices within the block
`define LCB_IDX_DISPLAY_BIAS_CONTROL  1'h0
`define LCB_IDX_QUICK_CHARGE_LEVEL    1'h1

// reset values
`define LCB_RST_DISPLAY_BIAS_CONTROL  8'h00
`define LCB_RST_QUICK_CHARGE_LEVEL    8'h00

// display_bias_control fields
`define LCB_BIT_DISPLAY_ENABLE        0
`define LCB_RSEL_LSB                  1
`define LCB_RSEL_MSB                  3
`define LCB_CAPSUP_LSB                4
`define LCB_CAPSUP_MSB                5
`define LCB_BIT_BIAS_STYLE            6
`define LCB_BIT_WAVE_TYPE             7

// quick_charge_level_control fields
`define LCB_LEVEL_LSB                 0
`define LCB_LEVEL_MSB                 3
`define LCB_QCT_LSB                   5
`define LCB_QCT_MSB                   7
`define LCB_QCL_WRITE_MASK            8'hEF

// power modes
`define LCB_MODE_FAST                 2'h0
`define LCB_MODE_SLOW                 2'h1
`define LCB_MODE_IDLE                 2'h2
`define LCB_MODE_SLEEP                2'h3

// active ladder resistance codes
`define LCB_RES_HIGH                  2'h0
`define LCB_RES_MID                   2'h1
`define LCB_RES_LOW                   2'h2

// top level in sixteenths of the panel supply
`define LCB_LEVEL_BASE                5'h08
`define LCB_LEVEL_FULL                5'h10

`endif

// ===== core/lcb_quick_charge.v
// quick charge timer counting lcd sub clock periods per common phase
`timescale 1ns/1ps
`default_nettype none

module lcb_quick_charge (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  // control
  input  wire       enable,
  input  wire       phase_start,
  input  wire       sub_tick,
  input  wire [2:0] quick_charge_time,
  // status
  output reg        active_q
);

  reg [2:0] cnt_q;

  // phase start wins over a tick landing in the same cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      active_q <= 1'b0;
      cnt_q    <= 3'h0;
    end else if (ce) begin
      if (!enable) begin
        active_q <= 1'b0;
        cnt_q    <= 3'h0;
      end else if (phase_start) begin
        active_q <= 1'b1;
        cnt_q    <= 3'h0;
      end else if (active_q && sub_tick) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == quick_charge_time) begin
          active_q <= 1'b0;
        end
      end
    end
  end

endmodule // lcb_quick_charge

`default_nettype wire

// ===== core/lcb_bias_regs.v
// lcd bias and waveform control register pair with bias steering
`timescale 1ns/1ps
`default_nettype none
`include "lcb_regs.vh"

module lcb_bias_regs (
  // clock, reset, clock enable
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  // data memory access
  input  wire       reg_index,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  // power mode of the device
  input  wire [1:0] power_mode,
  // lcd timing
  input  wire       sub_clk_pin,
  input  wire       common_line_phase,
  // steering outputs to the analog bias and waveform logic
  output reg        display_on_q,
  output reg        wave_type_b_q,
  output reg        charge_pump_en_q,
  output reg  [1:0] cap_supply_sel_q,
  output reg        ladder_dc_path_q,
  output reg  [1:0] ladder_res_sel_q,
  output reg  [4:0] ladder_top_level_q,
  output wire       quick_charge_active_q
);

  // stored register contents
  reg  [7:0] bias_ctrl_q;
  reg  [7:0] qcl_ctrl_q;

  // qualified write strobes, one per register
  wire       wr_bias_ctrl;
  wire       wr_qcl_ctrl;

  // sub clock synchroniser and edge detect
  reg        sub_meta_q;
  reg        sub_sync_q;
  reg        sub_prev_q;
  wire       sub_tick;

  // decoded fields
  wire       display_enable;
  wire       bias_style_select;
  wire       wave_type;
  wire [1:0] cap_bias_supply_select;
  wire [2:0] bias_resistor_select;
  wire [2:0] quick_charge_time;
  wire [3:0] ladder_top_level_select;

  // derived controls
  wire       mode_awake;
  wire       display_on_d;
  wire       r_bias_on;
  wire       quick_mode;
  wire       qc_enable;
  reg  [1:0] res_sel_d;
  reg  [4:0] top_level_d;
  reg  [7:0] rdata_d;

  // field extraction from the stored bytes
  assign display_enable         = bias_ctrl_q[`LCB_BIT_DISPLAY_ENABLE];
  assign bias_style_select      = bias_ctrl_q[`LCB_BIT_BIAS_STYLE];
  assign wave_type              = bias_ctrl_q[`LCB_BIT_WAVE_TYPE];
  assign cap_bias_supply_select =
    bias_ctrl_q[`LCB_CAPSUP_MSB:`LCB_CAPSUP_LSB];
  assign bias_resistor_select   = bias_ctrl_q[`LCB_RSEL_MSB:`LCB_RSEL_LSB];
  assign quick_charge_time      = qcl_ctrl_q[`LCB_QCT_MSB:`LCB_QCT_LSB];
  assign ladder_top_level_select =
    qcl_ctrl_q[`LCB_LEVEL_MSB:`LCB_LEVEL_LSB];

  // strobes are qualified by the clock enable here so that a frozen
  // block drops software writes instead of latching them late
  assign wr_bias_ctrl = ce & reg_wr &
                        (reg_index == `LCB_IDX_DISPLAY_BIAS_CONTROL);
  assign wr_qcl_ctrl  = ce & reg_wr &
                        (reg_index == `LCB_IDX_QUICK_CHARGE_LEVEL);

  // first register takes the whole byte
  always @(posedge clk_sys) begin
    if (rst) begin
      bias_ctrl_q <= `LCB_RST_DISPLAY_BIAS_CONTROL;
    end else if (wr_bias_ctrl) begin
      bias_ctrl_q <= reg_wdata;
    end
  end

  // second register; bit 4 of the byte never stores
  always @(posedge clk_sys) begin
    if (rst) begin
      qcl_ctrl_q <= `LCB_RST_QUICK_CHARGE_LEVEL;
    end else if (wr_qcl_ctrl) begin
      qcl_ctrl_q <= reg_wdata & `LCB_QCL_WRITE_MASK;
    end
  end

  // read mux; the unimplemented bit is already held at zero
  always @* begin
    if (reg_index == `LCB_IDX_DISPLAY_BIAS_CONTROL) begin
      rdata_d = bias_ctrl_q;
    end else begin
      rdata_d = qcl_ctrl_q & `LCB_QCL_WRITE_MASK;
    end
  end

  // read data is registered so it leaves from a flop
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // sub clock comes from another oscillator, so two flops first
  always @(posedge clk_sys) begin
    if (rst) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else if (ce) begin
      sub_meta_q <= sub_clk_pin;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  // one tick per rising sub clock edge marks one period
  // the tick lags the pin by about two system cycles, far below one
  // sub clock period, so the charge window is not visibly stretched
  assign sub_tick = sub_sync_q & ~sub_prev_q;

  // enable only counts in the awake modes; sleep overrides it
  assign mode_awake   = (power_mode != `LCB_MODE_SLEEP);
  assign display_on_d = display_enable & mode_awake;

  // resistor ladder is in use only for an enabled r type display
  // clearing the enable or entering sleep drops it, which opens the
  // ladder dc path and stops the bias current
  assign r_bias_on  = display_on_d & ~bias_style_select;
  assign quick_mode = (bias_resistor_select[2] |
                       (bias_resistor_select[1] & bias_resistor_select[0]));
  assign qc_enable  = r_bias_on & quick_mode;

  // quick charge timer per common phase
  // the timer is held clear outside quick r type operation, so a
  // mode change mid window cannot leave high current applied
  lcb_quick_charge lcb_quick_charge_i (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .ce                (ce),
    .enable            (qc_enable),
    .phase_start       (common_line_phase),
    .sub_tick          (sub_tick),
    .quick_charge_time (quick_charge_time),
    .active_q          (quick_charge_active_q)
  );

  // active resistance; quick modes drop to low while charging
  // fixed codes ignore the timer, so a stale active flag cannot
  // disturb them
  always @* begin
    case (bias_resistor_select)
      3'h0: res_sel_d = `LCB_RES_HIGH;
      3'h1: res_sel_d = `LCB_RES_MID;
      3'h2: res_sel_d = `LCB_RES_LOW;
      3'h3: begin
        if (quick_charge_active_q) begin
          res_sel_d = `LCB_RES_LOW;
        end else begin
          res_sel_d = `LCB_RES_HIGH;
        end
      end
      default: begin
        if (quick_charge_active_q) begin
          res_sel_d = `LCB_RES_LOW;
        end else begin
          res_sel_d = `LCB_RES_MID;
        end
      end
    endcase
  end

  // top ladder level in sixteenths of the panel supply
  always @* begin
    if (ladder_top_level_select[3]) begin
      top_level_d = `LCB_LEVEL_FULL;
    end else begin
      top_level_d = `LCB_LEVEL_BASE +
                    {2'h0, ladder_top_level_select[2:0]};
    end
  end

  // steering outputs, all registered to keep the analog side glitch free
  always @(posedge clk_sys) begin
    if (rst) begin
      display_on_q       <= 1'b0;
      wave_type_b_q      <= 1'b0;
      charge_pump_en_q   <= 1'b0;
      cap_supply_sel_q   <= 2'h0;
      ladder_dc_path_q   <= 1'b0;
      ladder_res_sel_q   <= `LCB_RES_HIGH;
      ladder_top_level_q <= `LCB_LEVEL_BASE;
    end else if (ce) begin
      display_on_q       <= display_on_d;
      wave_type_b_q      <= wave_type;
      // pump runs only for an enabled c type display
      charge_pump_en_q   <= display_on_d & bias_style_select;
      // passed through as written; software keeps 00 in r type
      cap_supply_sel_q   <= cap_bias_supply_select;
      // ladder current path opens when r type is off
      ladder_dc_path_q   <= r_bias_on;
      ladder_res_sel_q   <= res_sel_d;
      ladder_top_level_q <= top_level_d;
    end
  end

endmodule // lcb_bias_regs

`default_nettype wire

// ===== testbench/lcb_bias_regs_monitor.sv
// assertion checker for the lcd bias control register pair
`timescale 1ns/1ps
`default_nettype none
`include "lcb_regs.vh"

module lcb_bias_regs_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // bus and timing inputs
  input wire logic       ce,
  input wire logic       reg_index,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [1:0] power_mode,
  input wire logic       common_line_phase,
  // steering outputs
  input wire logic       display_on_q,
  input wire logic       wave_type_b_q,
  input wire logic       charge_pump_en_q,
  input wire logic       ladder_dc_path_q,
  input wire logic [1:0] ladder_res_sel_q,
  input wire logic [4:0] ladder_top_level_q,
  input wire logic       quick_charge_active_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // first register write, awake, then one quiet cycle
  sequence wr0_s;
    ce && reg_wr && !reg_index && power_mode != `LCB_MODE_SLEEP
      ##1 ce && !reg_wr && power_mode != `LCB_MODE_SLEEP;
  endsequence

  // second register write, then one quiet cycle
  sequence wr1_s;
    ce && reg_wr && reg_index ##1 ce && !reg_wr;
  endsequence

  chk_enable_follows:
    assert property (wr0_s |=> display_on_q == $past(reg_wdata[0], 2))
    else $error("display enable did not follow write");
  chk_wave_follows:
    assert property (wr0_s |=> wave_type_b_q == $past(reg_wdata[7], 2))
    else $error("wave type did not follow write");
  chk_sleep_off:
    assert property ((ce && power_mode == `LCB_MODE_SLEEP)[*2] |->
      !display_on_q)
    else $error("display on during sleep");
  chk_pump_path_excl:
    assert property (!(charge_pump_en_q && ladder_dc_path_q))
    else $error("charge pump and ladder path both on");
  chk_path_follows:
    assert property (wr0_s |=> ladder_dc_path_q ==
      $past(reg_wdata[0] & ~reg_wdata[6], 2))
    else $error("ladder path did not follow write");
  chk_pump_follows:
    assert property (wr0_s |=> charge_pump_en_q ==
      $past(reg_wdata[0] & reg_wdata[6], 2))
    else $error("charge pump did not follow write");
  chk_bit4_zero:
    assert property (ce && reg_rd && reg_index |=> !reg_rdata_q[4])
    else $error("unimplemented bit read as one");
  chk_qc_low_res:
    assert property ($rose(quick_charge_active_q) && ce |=>
      ladder_res_sel_q == `LCB_RES_LOW)
    else $error("low resistance not applied in quick charge");
  chk_qc_phase:
    assert property ($rose(quick_charge_active_q) |->
      $past(common_line_phase))
    else $error("quick charge started without phase");
  chk_qc_display:
    assert property (quick_charge_active_q |->
      display_on_q && ladder_dc_path_q)
    else $error("quick charge while display off");
  chk_level_range:
    assert property (ladder_top_level_q >= `LCB_LEVEL_BASE &&
      ladder_top_level_q <= `LCB_LEVEL_FULL)
    else $error("top level out of range");
  chk_level_follows:
    assert property (wr1_s |=> ladder_top_level_q ==
      ($past(reg_wdata[3], 2) ? `LCB_LEVEL_FULL :
       `LCB_LEVEL_BASE + {2'h0, $past(reg_wdata[2:0], 2)}))
    else $error("top level did not follow write");
endmodule // lcb_bias_regs_monitor

bind lcb_bias_regs lcb_bias_regs_monitor lcb_bias_regs_monitor_i (
  .clk_sys               (clk_sys),
  .rst                   (rst),
  .ce                    (ce),
  .reg_index             (reg_index),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_wdata             (reg_wdata),
  .reg_rdata_q           (reg_rdata_q),
  .power_mode            (power_mode),
  .common_line_phase     (common_line_phase),
  .display_on_q          (display_on_q),
  .wave_type_b_q         (wave_type_b_q),
  .charge_pump_en_q      (charge_pump_en_q),
  .ladder_dc_path_q      (ladder_dc_path_q),
  .ladder_res_sel_q      (ladder_res_sel_q),
  .ladder_top_level_q    (ladder_top_level_q),
  .quick_charge_active_q (quick_charge_active_q)
);
`default_nettype wire

// ===== testbench/lcb_bias_regs_tb.sv
// self-checking testbench for the lcd bias control register pair
`timescale 1ns/1ps
`default_nettype none
`include "lcb_regs.vh"

module lcb_bias_regs_tb;
  logic       clk_sys = 0, rst = 1, ce = 1, reg_index = 0;
  logic       reg_wr = 0, reg_rd = 0, sub_clk_pin = 0;
  logic       common_line_phase = 0;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] power_mode = 2'h0;
  wire  [7:0] reg_rdata_q;
  wire  [4:0] ladder_top_level_q;
  wire  [1:0] cap_supply_sel_q, ladder_res_sel_q;
  wire        display_on_q, wave_type_b_q, charge_pump_en_q;
  wire        ladder_dc_path_q, quick_charge_active_q;
  int         error_cnt = 0, num_checks = 0, cyc = 0;

  lcb_bias_regs lcb_bias_regs_i (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .ce                    (ce),
    .reg_index             (reg_index),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_wdata             (reg_wdata),
    .reg_rdata_q           (reg_rdata_q),
    .power_mode            (power_mode),
    .sub_clk_pin           (sub_clk_pin),
    .common_line_phase     (common_line_phase),
    .display_on_q          (display_on_q),
    .wave_type_b_q         (wave_type_b_q),
    .charge_pump_en_q      (charge_pump_en_q),
    .cap_supply_sel_q      (cap_supply_sel_q),
    .ladder_dc_path_q      (ladder_dc_path_q),
    .ladder_res_sel_q      (ladder_res_sel_q),
    .ladder_top_level_q    (ladder_top_level_q),
    .quick_charge_active_q (quick_charge_active_q)
  );

  // free running 50 mhz clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // hang guard, whole run is well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // write, then wait out the two cycle steering lag
  task automatic wr(logic i, logic [7:0] d);
    reg_index = i;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(2);
  endtask
  task automatic rd(logic i, logic [7:0] e);
    reg_index = i;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    tick(1);
    cmp("rdata", e, reg_rdata_q);
  endtask

  task automatic t_reset();
    rd(0, 8'h00);
    rd(1, 8'h00);
    cmp("top", `LCB_LEVEL_BASE, ladder_top_level_q);
    cmp("res", `LCB_RES_HIGH, ladder_res_sel_q);
  endtask
  // writes to both registers, masked bit, frozen clock enable
  task automatic t_regs();
    wr(0, 8'h85);
    wr(1, 8'hFF);
    rd(0, 8'h85);
    rd(1, 8'hEF);
    ce = 0;
    wr(0, 8'h00);
    ce = 1;
    rd(0, 8'h85);
  endtask
  task automatic t_bias();
    wr(0, 8'hC1);
    cmp("wave", 1, wave_type_b_q);
    cmp("pump", 1, charge_pump_en_q);
    for (int s = 0; s < 4; s++) begin
      wr(0, 8'h41 | (s << 4));
      cmp("capsup", s, cap_supply_sel_q);
    end
    wr(0, 8'h01);
    cmp("wave", 0, wave_type_b_q);
    cmp("path", 1, ladder_dc_path_q);
    cmp("pump", 0, charge_pump_en_q);
    wr(0, 8'h00);
    cmp("path", 0, ladder_dc_path_q);
  endtask
  task automatic t_sleep();
    wr(0, 8'h01);
    for (int m = 0; m < 4; m++) begin
      power_mode = m;
      tick(2);
      cmp("on", m != 3, display_on_q);
    end
    power_mode = `LCB_MODE_FAST;
  endtask
  task automatic t_sel();
    for (int r = 0; r < 3; r++) begin
      wr(0, 8'h01 | (r << 1));
      cmp("res", r, ladder_res_sel_q);
    end
    for (int c = 0; c < 16; c++) begin
      wr(1, c);
      cmp("top", c < 8 ? 8 + c : 16, ladder_top_level_q);
    end
  endtask
  // one phase, then qct+1 sub clock periods of high current
  task automatic qc(logic [2:0] r, logic [2:0] q, logic [1:0] e);
    wr(1, {q, 5'h00});
    wr(0, {4'h0, r, 1'b1});
    common_line_phase = 1;
    tick(1);
    common_line_phase = 0;
    tick(1);
    cmp("active", 1, quick_charge_active_q);
    cmp("res", `LCB_RES_LOW, ladder_res_sel_q);
    for (int k = 0; k <= q; k++) begin
      if (k == q) cmp("active", 1, quick_charge_active_q);
      sub_clk_pin = 1;
      tick(10);
      sub_clk_pin = 0;
      tick(10);
    end
    cmp("active", 0, quick_charge_active_q);
    cmp("res", e, ladder_res_sel_q);
  endtask

  // sleep during a quick charge window cuts it short
  task automatic t_qc_sleep();
    wr(0, 8'h07);
    common_line_phase = 1;
    tick(1);
    common_line_phase = 0;
    tick(1);
    cmp("active", 1, quick_charge_active_q);
    power_mode = `LCB_MODE_SLEEP;
    tick(2);
    cmp("active", 0, quick_charge_active_q);
    cmp("path", 0, ladder_dc_path_q);
    power_mode = `LCB_MODE_FAST;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    tick(16);
    rst = 0;
    t_reset();
    t_regs();
    t_bias();
    t_sleep();
    t_sel();
    qc(3'h3, 3'h2, `LCB_RES_HIGH);
    qc(3'h4, 3'h0, `LCB_RES_MID);
    qc(3'h7, 3'h7, `LCB_RES_MID);
    t_qc_sleep();
    finish_test();
  end
endmodule // lcb_bias_regs_tb
`default_nettype wire
